// ===== common/outcfg_pkg.sv
// Package: register map, field positions, codes and carrier types of the output config block
package outcfg_pkg;
    // Register indexes; the APB byte address is four times the index
    localparam logic [7:0]  IDX_AUX        = 8'h0A;
    localparam logic [7:0]  IDX_FMT        = 8'h0D;
    localparam logic [7:0]  IDX_DIV_LM     = 8'h0E;
    localparam logic [7:0]  IDX_DIV_H      = 8'h0F;
    localparam logic [7:0]  IDX_SPW        = 8'h10;
    localparam logic [7:0]  IDX_SPH        = 8'h11;
    localparam logic [7:0]  IDX_SPT        = 8'h12;
    localparam logic [7:0]  IDX_STATUS     = 8'h3F;
    // Storage slots of the shadowed configuration registers
    localparam int          CFG_SLOTS      = 7;
    localparam logic [2:0]  SLOT_AUX       = 3'h0;
    localparam logic [2:0]  SLOT_FMT       = 3'h1;
    localparam logic [2:0]  SLOT_DIV_LM    = 3'h2;
    localparam logic [2:0]  SLOT_DIV_H     = 3'h3;
    localparam logic [2:0]  SLOT_SPW       = 3'h4;
    localparam logic [2:0]  SLOT_SPH       = 3'h5;
    localparam logic [2:0]  SLOT_SPT       = 3'h6;
    localparam logic [15:0] CFG_RESET [CFG_SLOTS] = '{16'h0000, 16'h0007, 16'h0501, 16'h0003,
                                                      16'h0640, 16'h0258, 16'h0606};
    localparam logic [15:0] CFG_MASK  [CFG_SLOTS] = '{16'hFFFF, 16'h0FFF, 16'hEFEF, 16'h00EF,
                                                      16'h0FFF, 16'h0FFF, 16'hFFFF};
    // Output format control fields
    localparam int          FMT_SPOOF_EN   = 0;
    localparam int          FMT_VAR_RATE   = 6;
    localparam int          FMT_SYNC_CODES = 10;
    localparam int          FMT_FREEZE     = 11;
    // Divisor fields
    localparam int          DIV_W          = 4;
    localparam int          DIV_LOW_LSB    = 0;
    localparam int          DIV_MID_LSB    = 8;
    localparam int          DIV_HIGH_LSB   = 0;
    // Status register fields
    localparam int          STAT_SEL_LSB   = 0;
    localparam int          STAT_ADAPT_LSB = 2;
    localparam int          STAT_FREEZE    = 4;
    localparam int          STAT_INSERT    = 5;
    // Sync markers, sent most significant byte first
    localparam logic [31:0] FRAME_START_MARKER = 32'hFF0000AB;
    localparam logic [31:0] FRAME_END_MARKER   = 32'hFF0000B6;
    localparam logic [31:0] LINE_START_MARKER  = 32'hFF000080;
    localparam logic [31:0] LINE_END_MARKER    = 32'hFF00009D;
    localparam logic [1:0]  MARKER_LAST        = 2'h3;

    typedef enum logic [1:0] {SRC_LOW, SRC_MID, SRC_HIGH} clk_src_t;
    typedef enum logic [2:0] {MK_PASS, MK_FS, MK_LS, MK_LE, MK_FE} marker_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic       sof;
        logic       line_start_marker;
        logic       line_end_marker;
        logic       eof;
    } pix_beat_t;

    typedef struct packed {
        logic [11:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;
endpackage

// ===== dv/host_capture_model.sv
// Host capture model: takes output bytes and can stall every other cycle
module host_capture_model (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       slow,
    input  wire logic       out_valid,
    input  wire logic [7:0] out_data,
    output      logic       out_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got[$];
    logic       phase = 1'h0;
    initial out_ready = 1'h0;
    always @(posedge mclk) begin
        if (out_valid === 1'h1 && out_ready === 1'h1) begin
            got.push_back(out_data);
        end
        phase <= ~phase;
        out_ready <= !rst && (!slow || phase);
    end
endmodule

// ===== dv/jpeg_output_clock_and_shadow_cfg_bench.sv
// Bench of the output clock and shadow configuration block
module jpeg_output_clock_and_shadow_cfg_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DEPTH = 16;
    logic                  mclk = 1'h0;
    logic                  rst = 1'h1;
    logic                  ce = 1'h1;
    outcfg_pkg::apb_req_t  req = '0;
    outcfg_pkg::apb_rsp_t  rsp;
    logic                  vblank = 1'h1;
    logic                  uncomp = 1'h1;
    logic [4:0]            fill = 5'h00;
    logic                  pix_valid = 1'h0;
    logic                  pix_ready;
    outcfg_pkg::pix_beat_t pix = '0;
    logic                  out_valid, out_ready, pclk, tick;
    logic [7:0]            out_data;
    logic                  slow = 1'h0;
    logic [15:0]           rd;
    logic                  err;
    int                    num_errors = 0;
    int                    checked = 0;
    always #5 mclk = ~mclk;

    output_clock_cfg #(.FIFO_DEPTH(DEPTH)) u_output_clock_cfg (
        .mclk(mclk), .rst(rst), .ce(ce), .apb_req(req), .apb_rsp(rsp), .in_vblank(vblank),
        .uncompressed(uncomp), .fifo_fill(fill), .pix_valid(pix_valid), .pix_ready(pix_ready),
        .pix_in(pix), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
        .pixel_output_clock(pclk), .pixel_clock_tick(tick));
    host_capture_model u_host_capture_model (.mclk(mclk), .rst(rst), .slow(slow),
        .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
        @(posedge mclk);
        req <= '{paddr: {2'h0, idx, 2'h0}, psel: 1'h1, penable: 1'h0, pwrite: wr,
                 pwdata: {16'h0000, wd}};
        @(posedge mclk);
        req.penable <= 1'h1;
        do begin
            @(posedge mclk);
        end while (rsp.pready !== 1'h1);
        rd = rsp.prdata[15:0];
        err = rsp.pslverr;
        req.psel <= 1'h0;
        req.penable <= 1'h0;
    endtask
    task automatic frame_start;
        @(posedge mclk);
        vblank <= 1'h1;
        repeat (4) @(posedge mclk);
        vblank <= 1'h0;
        repeat (6) @(posedge mclk);
    endtask
    task automatic ticks(input string what, input int n);
        int c;
        int h;
        c = 0;
        h = 0;
        repeat (24) @(posedge mclk);
        repeat (48) begin
            @(posedge mclk);
            if (tick === 1'h1) c++;
            if (pclk === 1'h1) h++;
        end
        chk(what, c, 48 / n);
        chk(what, h, (48 / n) * ((n + 1) / 2));
    endtask
    task automatic send(input logic [7:0] d, input logic [3:0] f);
        @(posedge mclk);
        pix_valid <= 1'h1;
        pix <= {d, f};
        do begin
            @(posedge mclk);
        end while (pix_ready !== 1'h1);
        pix_valid <= 1'h0;
    endtask

    task automatic test_reset;
        apb(1'h0, outcfg_pkg::IDX_FMT, 16'h0000);
        chk("format reset", rd, 16'h0007);
        apb(1'h0, outcfg_pkg::IDX_DIV_LM, 16'h0000);
        chk("divider low mid reset", rd, 16'h0501);
        apb(1'h0, outcfg_pkg::IDX_DIV_H, 16'h0000);
        chk("divider high reset", rd, 16'h0003);
        apb(1'h0, 8'h20, 16'h0000);
        chk("unmapped error", err, 1'h1);
        ticks("low source at reset", 1);
        $display("test reset done");
    endtask
    task automatic test_markers;
        logic [143:0] exp;
        exp = {outcfg_pkg::FRAME_START_MARKER, outcfg_pkg::LINE_START_MARKER, 8'hA5, 8'h3C,
               outcfg_pkg::LINE_END_MARKER, outcfg_pkg::FRAME_END_MARKER};
        apb(1'h1, outcfg_pkg::IDX_FMT, 16'h0401);
        frame_start;
        apb(1'h0, outcfg_pkg::IDX_STATUS, 16'h0000);
        chk("status insert", rd, 16'h0020);
        slow <= 1'h1;
        send(8'hA5, 4'hC);
        send(8'h3C, 4'h3);
        repeat (80) @(posedge mclk);
        chk("stream length", u_host_capture_model.got.size(), 18);
        for (int i = 0; i < 18; i++) begin
            chk("stream byte", u_host_capture_model.got[i], exp[143 - 8 * i -: 8]);
        end
        slow <= 1'h0;
        $display("test markers done");
    endtask
    task automatic test_adaptive;
        int fl[8] = '{7, 8, 11, 12, 8, 7, 4, 3};
        int nd[8] = '{4, 3, 3, 2, 2, 3, 3, 4};
        apb(1'h1, outcfg_pkg::IDX_DIV_LM, 16'h0304);
        apb(1'h1, outcfg_pkg::IDX_DIV_H, 16'h0002);
        apb(1'h1, outcfg_pkg::IDX_FMT, 16'h0047);
        frame_start;
        for (int i = 0; i < 8; i++) begin
            fill <= fl[i][4:0];
            ticks("adaptive source rate", nd[i]);
        end
        apb(1'h1, outcfg_pkg::IDX_FMT, 16'h0007);
        frame_start;
        fill <= 5'h0F;
        ticks("fixed low source", 4);
        fill <= 5'h00;
        $display("test adaptive done");
    endtask
    task automatic test_freeze;
        apb(1'h1, outcfg_pkg::IDX_FMT, 16'h0807);
        apb(1'h1, outcfg_pkg::IDX_DIV_LM, 16'h0306);
        apb(1'h0, outcfg_pkg::IDX_STATUS, 16'h0000);
        chk("status freeze", rd, 16'h0010);
        frame_start;
        ticks("frozen shadow", 4);
        apb(1'h0, outcfg_pkg::IDX_DIV_LM, 16'h0000);
        chk("register keeps write", rd, 16'h0306);
        apb(1'h1, outcfg_pkg::IDX_FMT, 16'h0007);
        ticks("shadow within frame", 4);
        frame_start;
        ticks("shadow loaded", 6);
        apb(1'h1, outcfg_pkg::IDX_DIV_LM, 16'h0300);
        frame_start;
        ticks("zero divisor", 1);
        $display("test freeze done");
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'h0;
        test_reset;
        test_markers;
        test_adaptive;
        test_freeze;
        give_verdict;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        give_verdict;
    end
endmodule

// ===== rtl/output_clock_cfg.sv
// Output stage configuration: shadow registers, sync-code insertion, adaptive pixel clock
//
// Register access over APB was decided locally.
module output_clock_cfg #(
    parameter int FIFO_DEPTH = 512,
    parameter int FW         = $clog2(FIFO_DEPTH + 1)
) (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire logic                  ce,
    input  wire outcfg_pkg::apb_req_t  apb_req,
    output      outcfg_pkg::apb_rsp_t  apb_rsp,
    input  wire logic                  in_vblank,
    input  wire logic                  uncompressed,
    input  wire logic [FW-1:0]         fifo_fill,
    input  wire logic                  pix_valid,
    output      logic                  pix_ready,
    input  wire outcfg_pkg::pix_beat_t pix_in,
    output      logic                  out_valid,
    input  wire logic                  out_ready,
    output      logic [7:0]            out_data,
    output      logic                  pixel_output_clock,
    output      logic                  pixel_clock_tick
);
    localparam logic [FW+1:0] TH_FULL = (FW + 2)'(FIFO_DEPTH);
    localparam logic [FW+1:0] TH_3Q   = (FW + 2)'(3 * FIFO_DEPTH);

    typedef struct packed {
        logic [outcfg_pkg::CFG_SLOTS-1:0][15:0]   cfg;
        logic [outcfg_pkg::CFG_SLOTS-1:0][15:0]   shadow;
        logic [1:0]                               vb_sync;
        logic                                     vb_prev;
        logic [31:0]                              prdata;
        outcfg_pkg::marker_state_t                mk;
        logic [1:0]                               mk_cnt;
        logic                                     hdr_done;
        logic                                     eof_pend;
        logic                                     out_valid;
        logic [7:0]                               out_data;
        logic [2:0][outcfg_pkg::DIV_W-1:0]        div_cnt;
        outcfg_pkg::clk_src_t                     sel;
        outcfg_pkg::clk_src_t                     adapt;
        logic                                     pclk;
        logic                                     tick;
    } state_t;

    state_t                       st_reg;
    state_t                       st_next;
    state_t                       st_reset;
    logic [7:0]                   widx;
    logic                         hit;
    logic [2:0]                   slot;
    logic                         setup_ph;
    logic                         access_ph;
    logic                         frame_start;
    logic                         frz;
    logic                         ins;
    logic                         load;
    logic                         need_hdr;
    logic [31:0]                  marker;
    logic [FW+1:0]                fill_x2;
    logic [FW+1:0]                fill_x4;
    logic [2:0][outcfg_pkg::DIV_W-1:0] eff_div;
    logic [2:0]                   src_lvl;
    logic [2:0]                   src_wrap;
    logic [2:0]                   restart;
    logic                         do_switch;

    // Reset image of the whole state
    always_comb begin
        st_reset = '0;
        for (int i = 0; i < outcfg_pkg::CFG_SLOTS; i++) begin
            st_reset.cfg[i]    = outcfg_pkg::CFG_RESET[i];
            st_reset.shadow[i] = outcfg_pkg::CFG_RESET[i];
        end
        st_reset.mk    = outcfg_pkg::MK_PASS;
        st_reset.sel   = outcfg_pkg::SRC_LOW;
        st_reset.adapt = outcfg_pkg::SRC_LOW;
    end

    // APB address decode
    assign widx      = apb_req.paddr[9:2];
    assign setup_ph  = apb_req.psel && !apb_req.penable;
    assign access_ph = apb_req.psel && apb_req.penable;
    always_comb begin
        hit  = 1'b1;
        slot = outcfg_pkg::SLOT_AUX;
        if (apb_req.paddr[11:10] != 2'h0) begin
            hit = 1'b0;
        end else if (widx == outcfg_pkg::IDX_AUX) begin
            slot = outcfg_pkg::SLOT_AUX;
        end else if (widx == outcfg_pkg::IDX_FMT) begin
            slot = outcfg_pkg::SLOT_FMT;
        end else if (widx == outcfg_pkg::IDX_DIV_LM) begin
            slot = outcfg_pkg::SLOT_DIV_LM;
        end else if (widx == outcfg_pkg::IDX_DIV_H) begin
            slot = outcfg_pkg::SLOT_DIV_H;
        end else if (widx == outcfg_pkg::IDX_SPW) begin
            slot = outcfg_pkg::SLOT_SPW;
        end else if (widx == outcfg_pkg::IDX_SPH) begin
            slot = outcfg_pkg::SLOT_SPH;
        end else if (widx == outcfg_pkg::IDX_SPT) begin
            slot = outcfg_pkg::SLOT_SPT;
        end else if (widx != outcfg_pkg::IDX_STATUS) begin
            hit = 1'b0;
        end
    end

    assign apb_rsp.pready  = access_ph && ce;
    assign apb_rsp.pslverr = access_ph && ce && !hit;
    assign apb_rsp.prdata  = st_reg.prdata;

    // Control derived from live and shadow values
    assign frame_start = st_reg.vb_prev && !st_reg.vb_sync[1];
    assign frz         = st_reg.cfg[outcfg_pkg::SLOT_FMT][outcfg_pkg::FMT_FREEZE];
    assign ins         = st_reg.shadow[outcfg_pkg::SLOT_FMT][outcfg_pkg::FMT_SPOOF_EN]
                      && st_reg.shadow[outcfg_pkg::SLOT_FMT][outcfg_pkg::FMT_SYNC_CODES]
                      && uncompressed;
    assign load        = !st_reg.out_valid || out_ready;
    assign need_hdr    = ins && (pix_in.sof || pix_in.line_start_marker) && !st_reg.hdr_done;
    assign pix_ready   = ce && load && (st_reg.mk == outcfg_pkg::MK_PASS) && !need_hdr;
    assign out_valid   = st_reg.out_valid;
    assign out_data    = st_reg.out_data;
    assign fill_x2     = {1'b0, fifo_fill, 1'b0};
    assign fill_x4     = {fifo_fill, 2'b00};

    always_comb begin
        case (st_reg.mk)
            outcfg_pkg::MK_FS: marker = outcfg_pkg::FRAME_START_MARKER;
            outcfg_pkg::MK_FE: marker = outcfg_pkg::FRAME_END_MARKER;
            outcfg_pkg::MK_LS: marker = outcfg_pkg::LINE_START_MARKER;
            default:           marker = outcfg_pkg::LINE_END_MARKER;
        endcase
    end

    // Divisors from shadow copies, zero treated as one
    assign eff_div[0] = st_reg.shadow[outcfg_pkg::SLOT_DIV_LM][outcfg_pkg::DIV_LOW_LSB +: 4];
    assign eff_div[1] = st_reg.shadow[outcfg_pkg::SLOT_DIV_LM][outcfg_pkg::DIV_MID_LSB +: 4];
    assign eff_div[2] = st_reg.shadow[outcfg_pkg::SLOT_DIV_H][outcfg_pkg::DIV_HIGH_LSB +: 4];

    // Three divided sources: high for ceil(N/2) cycles, low for the rest
    for (genvar g = 0; g < 3; g++) begin : g_src
        logic [outcfg_pkg::DIV_W-1:0] n;
        assign n           = (eff_div[g] == 4'h0) ? 4'h1 : eff_div[g];
        assign src_lvl[g]  = {1'b0, st_reg.div_cnt[g]} < (({1'b0, n} + 5'h01) >> 1);
        assign src_wrap[g] = st_reg.div_cnt[g] >= (n - 4'h1);
        assign restart[g]  = do_switch && (st_reg.adapt == outcfg_pkg::clk_src_t'(g));
    end

    // Change source only at the end of a whole period of the current one
    assign do_switch = src_wrap[st_reg.sel] && (st_reg.adapt != st_reg.sel);

    assign pixel_output_clock = st_reg.pclk;
    assign pixel_clock_tick   = st_reg.tick;

    always_comb begin
        st_next = st_reg;
        // Input blanking level from another domain
        st_next.vb_sync = {st_reg.vb_sync[0], in_vblank};
        st_next.vb_prev = st_reg.vb_sync[1];
        // Register access
        if (setup_ph && !apb_req.pwrite) begin
            st_next.prdata = '0;
            if (widx == outcfg_pkg::IDX_STATUS) begin
                st_next.prdata[outcfg_pkg::STAT_SEL_LSB +: 2]   = st_reg.sel;
                st_next.prdata[outcfg_pkg::STAT_ADAPT_LSB +: 2] = st_reg.adapt;
                st_next.prdata[outcfg_pkg::STAT_FREEZE]         = frz;
                st_next.prdata[outcfg_pkg::STAT_INSERT]         = ins;
            end else if (hit) begin
                st_next.prdata[15:0] = st_reg.cfg[slot];
            end
        end
        if (access_ph && apb_req.pwrite && hit && widx != outcfg_pkg::IDX_STATUS) begin
            st_next.cfg[slot] = apb_req.pwdata[15:0] & outcfg_pkg::CFG_MASK[slot];
        end
        // Shadow load at end of vertical blanking unless frozen
        if (frame_start && !frz) begin
            st_next.shadow = st_reg.cfg;
        end
        // Marker insertion around each line and frame
        if (out_ready) begin
            st_next.out_valid = 1'b0;
        end
        if (load) begin
            case (st_reg.mk)
                outcfg_pkg::MK_PASS: begin
                    if (pix_valid && need_hdr) begin
                        st_next.mk     = pix_in.sof ? outcfg_pkg::MK_FS : outcfg_pkg::MK_LS;
                        st_next.mk_cnt = 2'h0;
                    end else if (pix_valid) begin
                        st_next.out_valid = 1'b1;
                        st_next.out_data  = pix_in.data;
                        st_next.hdr_done  = 1'b0;
                        if (ins && pix_in.line_end_marker) begin
                            st_next.mk       = outcfg_pkg::MK_LE;
                            st_next.mk_cnt   = 2'h0;
                            st_next.eof_pend = pix_in.eof;
                        end
                    end
                end
                default: begin
                    st_next.out_valid = 1'b1;
                    st_next.out_data  = marker[(5'd31 - {st_reg.mk_cnt, 3'b000}) -: 8];
                    st_next.mk_cnt    = st_reg.mk_cnt + 2'h1;
                    if (st_reg.mk_cnt == outcfg_pkg::MARKER_LAST) begin
                        case (st_reg.mk)
                            outcfg_pkg::MK_FS: st_next.mk = outcfg_pkg::MK_LS;
                            outcfg_pkg::MK_LE: begin
                                st_next.mk = st_reg.eof_pend ? outcfg_pkg::MK_FE
                                                             : outcfg_pkg::MK_PASS;
                            end
                            default: st_next.mk = outcfg_pkg::MK_PASS;
                        endcase
                        st_next.hdr_done = (st_reg.mk == outcfg_pkg::MK_LS);
                    end
                end
            endcase
        end
        // Adaptive source choice with hysteresis
        if (frame_start ||
            !st_reg.shadow[outcfg_pkg::SLOT_FMT][outcfg_pkg::FMT_VAR_RATE]) begin
            st_next.adapt = outcfg_pkg::SRC_LOW;
        end else begin
            case (st_reg.adapt)
                outcfg_pkg::SRC_LOW: begin
                    if (fill_x2 >= TH_FULL) begin
                        st_next.adapt = outcfg_pkg::SRC_MID;
                    end
                end
                outcfg_pkg::SRC_MID: begin
                    if (fill_x4 >= TH_3Q) begin
                        st_next.adapt = outcfg_pkg::SRC_HIGH;
                    end else if (fill_x4 < TH_FULL) begin
                        st_next.adapt = outcfg_pkg::SRC_LOW;
                    end
                end
                default: begin
                    if (fill_x2 < TH_FULL) begin
                        st_next.adapt = outcfg_pkg::SRC_MID;
                    end
                end
            endcase
        end
        // Dividers and output clock
        if (do_switch) begin
            st_next.sel = st_reg.adapt;
        end
        for (int i = 0; i < 3; i++) begin
            if (restart[i] || src_wrap[i]) begin
                st_next.div_cnt[i] = 4'h0;
            end else begin
                st_next.div_cnt[i] = st_reg.div_cnt[i] + 4'h1;
            end
        end
        st_next.pclk = src_lvl[st_reg.sel];
        st_next.tick = src_wrap[st_reg.sel];
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg <= st_reset;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // Checks
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    insert_start_a: assert property (
        (pix_valid && pix_ready && ins && pix_in.sof)
        |-> st_reg.hdr_done && (st_reg.out_data == 8'h80))
        else $error("frame start byte passed without leading markers");

    frame_start_code_a: assert property (
        (ce && load && st_reg.mk == outcfg_pkg::MK_FS && st_reg.mk_cnt == 2'h3)
        |=> (st_reg.out_data == 8'hAB) && st_reg.out_valid && (st_reg.mk == outcfg_pkg::MK_LS))
        else $error("frame start marker wrong");

    line_end_code_a: assert property (
        (ce && load && st_reg.mk == outcfg_pkg::MK_LE && st_reg.mk_cnt == 2'h3)
        |=> (st_reg.out_data == 8'h9D) && st_reg.out_valid)
        else $error("line end marker wrong");

    freeze_hold_a: assert property (
        (ce && frame_start && frz) |=> $stable(st_reg.shadow))
        else $error("shadow changed while frozen");

    freeze_direct_a: assert property (
        (ce && frame_start && st_reg.cfg[outcfg_pkg::SLOT_FMT][outcfg_pkg::FMT_FREEZE]
         && !st_reg.shadow[outcfg_pkg::SLOT_FMT][outcfg_pkg::FMT_FREEZE])
        |=> $stable(st_reg.shadow))
        else $error("freeze bit did not act at once");

    shadow_load_a: assert property (
        (ce && frame_start && !frz) |=> (st_reg.shadow == $past(st_reg.cfg)))
        else $error("shadow not loaded at end of blanking");

    shadow_steady_a: assert property (
        (ce && !frame_start) |=> $stable(st_reg.shadow))
        else $error("shadow changed during a frame");

    low_divider_a: assert property (
        (ce && st_reg.div_cnt[0] == 4'h0 && eff_div[0] == 4'h4 && !restart[0])
        |=> (st_reg.div_cnt[0] == 4'h1))
        else $error("low source counter misstep");

    zero_divisor_a: assert property (
        (ce && eff_div[2] == 4'h0) |=> (st_reg.div_cnt[2] == 4'h0))
        else $error("zero divisor not treated as one");

    step_up_mid_a: assert property (
        (ce && !frame_start && st_reg.adapt == outcfg_pkg::SRC_LOW && fill_x2 >= TH_FULL
         && st_reg.shadow[outcfg_pkg::SLOT_FMT][outcfg_pkg::FMT_VAR_RATE])
        |=> (st_reg.adapt == outcfg_pkg::SRC_MID))
        else $error("no step to mid source at half full");

    step_up_high_a: assert property (
        (ce && !frame_start && st_reg.adapt == outcfg_pkg::SRC_MID && fill_x4 >= TH_3Q
         && st_reg.shadow[outcfg_pkg::SLOT_FMT][outcfg_pkg::FMT_VAR_RATE])
        |=> (st_reg.adapt == outcfg_pkg::SRC_HIGH))
        else $error("no step to high source at three quarters");

    fixed_rate_a: assert property (
        (ce && !st_reg.shadow[outcfg_pkg::SLOT_FMT][outcfg_pkg::FMT_VAR_RATE])
        |=> (st_reg.adapt == outcfg_pkg::SRC_LOW))
        else $error("adaptive switching while disabled");

    frame_low_a: assert property (
        (ce && frame_start) |=> (st_reg.adapt == outcfg_pkg::SRC_LOW))
        else $error("frame did not start on low source");

    clean_switch_a: assert property (
        (ce && $changed(st_reg.sel)) |-> st_reg.tick ##1 st_reg.pclk)
        else $error("source switch not on period boundary");

    cov_frame_marker: cover property (ce && load && st_reg.mk == outcfg_pkg::MK_FS);
    cov_high_source:  cover property (st_reg.sel == outcfg_pkg::SRC_HIGH);
    cov_frozen_blank: cover property (ce && frame_start && frz);
    cov_bad_address:  cover property (apb_rsp.pslverr);
endmodule
